// file: rtl/fbr_top.sv
// Burst-read length control: register file, sample FIFO and byte sequencer
`timescale 1ns/100ps
`default_nettype none
module fbr_top (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire fbr_pkg::fbr_reg_req_t         reg_req,
  output logic                      [7:0]    reg_rdata,
  input  wire logic                          sample_valid,
  output logic                               sample_ready,
  input  wire logic [fbr_pkg::SAMPLE_W-1:0]  sample_data,
  input  wire logic [7:0]                    status_a,
  input  wire logic [7:0]                    status_b,
  input  wire logic [1:0]                    status_bytes,
  input  wire logic                          burst_start,
  output logic                               burst_busy,
  output logic                      [7:0]    burst_byte,
  output logic                               burst_byte_valid,
  output logic                               burst_last,
  input  wire logic                          burst_byte_ready
);
  import fbr_pkg::*;

  fbr_state_t st, next_st;
  logic              fo_valid;
  logic              fo_ready;
  logic [SAMPLE_W-1:0] fo_data;
  logic              fi_ready;

  fbr_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .in_valid (sample_valid),
    .in_ready (fi_ready),
    .in_data  (sample_data),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data (fo_data)
  );

  // Reset image: count and control at their power-on values, all else clear
  localparam fbr_state_t ST_RESET = '{
    fifo_ctrl:                FIFO_CTRL_RESET,
    burst_read_sample_length: READ_COUNT_RESET,
    phase:                    FBR_IDLE,
    default:                  '0
  };

  function automatic logic burst_on(input logic [7:0] ctrl);
    burst_on = ctrl[FIFO_BURST_BIT];
  endfunction

  // Samples sent for one start: the register count only in burst mode
  function automatic logic [7:0] burst_count(input logic [7:0] ctrl,
                                             input logic [7:0] cnt);
    if (burst_on(ctrl)) begin
      burst_count = cnt;
    end else begin
      burst_count = 8'h01;
    end
  endfunction

  function automatic logic [7:0] data_byte(input logic [SAMPLE_W-1:0] s,
                                           input logic [2:0]          i);
    data_byte = s[{i, 3'h0} +: 8];
  endfunction

  // Reserved count three is read as two, so a sample never exceeds eight bytes
  function automatic logic [1:0] stat_limit(input logic [1:0] n);
    if (n > STATUS_TWO) begin
      stat_limit = STATUS_TWO;
    end else begin
      stat_limit = n;
    end
  endfunction

  function automatic logic [7:0] status_pick(input logic [1:0] idx,
                                             input logic [7:0] a,
                                             input logic [7:0] b);
    if (idx == 2'h0) begin
      status_pick = a;
    end else begin
      status_pick = b;
    end
  endfunction

  logic [1:0] stat_cnt;
  logic       out_free;
  assign stat_cnt = stat_limit(status_bytes);
  assign out_free = !st.out_valid || burst_byte_ready;
  // A sample leaves the FIFO only when byte zero of it can be loaded
  assign fo_ready = (st.phase == FBR_DATA) && (st.byte_idx == 3'h0) && out_free;

  // One pass computes the whole next state
  always_comb begin
    next_st = st;
    // Consumer took the byte, so the output slot is free again
    if (st.out_valid && burst_byte_ready) begin
      next_st.out_valid = 1'b0;
      next_st.out_last  = 1'b0;
    end

    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_FIFO_CTRL:  next_st.fifo_ctrl = reg_req.wdata;
        ADDR_READ_COUNT: next_st.burst_read_sample_length = reg_req.wdata;
        default: ;
      endcase
    end

    // Read data are registered and answer on the next cycle
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_FIFO_CTRL:  next_st.rdata = st.fifo_ctrl;
        ADDR_READ_COUNT: next_st.rdata = st.burst_read_sample_length;
        ADDR_STATUS_A:   next_st.rdata = status_a;
        ADDR_STATUS_B:   next_st.rdata = status_b;
        default:         next_st.rdata = 8'h00;
      endcase
    end

    // Byte sequencer
    // A start is taken only when idle, so a start while busy is ignored
    case (st.phase)
      FBR_IDLE: begin
        if (burst_start) begin
          next_st.busy = 1'b1;
          next_st.byte_idx = 3'h0;
          next_st.stat_idx = 2'h0;
          next_st.phase = FBR_DATA;
          next_st.samples_left = burst_count(st.fifo_ctrl, st.burst_read_sample_length);
          // A count of zero in burst mode sends nothing
          if (burst_count(st.fifo_ctrl, st.burst_read_sample_length) == 8'h00) begin
            next_st.phase = FBR_IDLE;
            next_st.busy  = 1'b0;
          end
        end
      end

      // Byte zero pops a fresh sample; the other five come from the held copy
      FBR_DATA: begin
        if (out_free) begin
          if (st.byte_idx == 3'h0) begin
            if (fo_valid) begin
              next_st.sample = fo_data;
              next_st.out_byte = data_byte(fo_data, 3'h0);
              next_st.out_valid = 1'b1;
              next_st.byte_idx = 3'h1;
            end
          end else begin
            next_st.out_byte = data_byte(st.sample, st.byte_idx);
            next_st.out_valid = 1'b1;
            if (st.byte_idx == DATA_BYTES - 3'h1) begin
              next_st.byte_idx = 3'h0;
              if (stat_cnt == STATUS_NONE) begin
                next_st.samples_left = st.samples_left - 8'h01;
              end else begin
                next_st.phase = FBR_STAT;
              end
            end else begin
              next_st.byte_idx = st.byte_idx + 3'h1;
            end
          end
        end
        // Close the burst once the last whole sample has been queued
        if (next_st.phase == FBR_DATA && next_st.byte_idx == 3'h0 &&
            next_st.samples_left == 8'h00) begin
          next_st.out_last = next_st.out_valid;
          next_st.phase = FBR_IDLE;
          next_st.busy = 1'b0;
        end
      end

      FBR_STAT: begin
        if (out_free) begin
          next_st.out_byte = status_pick(st.stat_idx, status_a, status_b);
          next_st.out_valid = 1'b1;
          if (st.stat_idx + 2'h1 >= stat_cnt) begin
            next_st.stat_idx = 2'h0;
            next_st.samples_left = st.samples_left - 8'h01;
            next_st.phase = FBR_DATA;
            if (st.samples_left == 8'h01) begin
              next_st.out_last = 1'b1;
              next_st.phase = FBR_IDLE;
              next_st.busy = 1'b0;
            end
          end else begin
            next_st.stat_idx = st.stat_idx + 2'h1;
          end
        end
      end
      default: next_st.phase = FBR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Asynchronous reset loads the power-on image
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flops
  assign sample_ready     = fi_ready;
  assign reg_rdata        = st.rdata;
  assign burst_busy       = st.busy;
  assign burst_byte       = st.out_byte;
  assign burst_byte_valid = st.out_valid;
  assign burst_last       = st.out_last;
endmodule
`default_nettype wire

// file: rtl/fbr_pkg.sv
// Constants and types for the FIFO burst-read length control block
// Summary of operation
// - With burst enabled, read count sets samples returned per burst read.
// - Each sample is six data bytes plus zero, one or two status bytes.
// - Count is in samples; host reads count times sample byte length.
// - With burst disabled, the read count register is ignored for reads.
// - Read count resets to six and all eight bits read and write.
package fbr_pkg;
  localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h30;
  localparam int         FIFO_BURST_BIT   = 7;
  localparam logic [7:0] ADDR_READ_COUNT  = 8'h4b;
  localparam logic [7:0] ADDR_STATUS_A    = 8'h13;
  localparam logic [7:0] ADDR_STATUS_B    = 8'h14;
  localparam logic [7:0] READ_COUNT_RESET = 8'h06;
  localparam logic [7:0] FIFO_CTRL_RESET  = 8'h00;
  localparam logic [2:0] DATA_BYTES       = 3'h6;
  localparam logic [1:0] STATUS_NONE      = 2'h0;
  localparam logic [1:0] STATUS_ONE       = 2'h1;
  localparam logic [1:0] STATUS_TWO       = 2'h2;
  localparam int         SAMPLE_W         = 48;
  localparam int         FIFO_DEPTH       = 16;

  typedef enum logic [1:0] {
    FBR_IDLE,
    FBR_DATA,
    FBR_STAT
  } fbr_phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fbr_reg_req_t;

  typedef struct packed {
    logic [7:0] fifo_ctrl;
    logic [7:0] burst_read_sample_length;
    logic [7:0] rdata;
    fbr_phase_t phase;
    logic [7:0] samples_left;
    logic [2:0] byte_idx;
    logic [1:0] stat_idx;
    logic [SAMPLE_W-1:0] sample;
    logic [7:0] out_byte;
    logic       out_valid;
    logic       out_last;
    logic       busy;
  } fbr_state_t;
endpackage

// file: rtl/fbr_fifo.sv
// Sample FIFO with valid/ready on both sides and registered read data
`timescale 1ns/100ps
`default_nettype none
module fbr_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int          AW      = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic             ov;
    logic             rdy;
    logic [WIDTH-1:0] od;
  } fbr_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  fbr_fifo_st_t st, next_st;
  logic        empty, push, pop;
  logic [AW:0] used_n;

  assign empty    = (st.wp == st.rp);
  // Ready is a flop; the output register counts as one of the DEPTH places
  assign in_ready = st.rdy;
  assign push     = in_valid && st.rdy;
  assign pop      = !empty && (!st.ov || out_ready);
  assign out_valid = st.ov;
  assign out_data  = st.od;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (st.ov && out_ready) begin
      next_st.ov = 1'b0;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
      next_st.ov = 1'b1;
      next_st.od = mem[st.rp[AW-1:0]];
    end
    used_n      = next_st.wp - next_st.rp;
    next_st.rdy = !((used_n == DEPTH_W) || (next_st.ov && (used_n == DEPTH_W - 1'b1)));
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// file: sim/fbr_checker.sv
// Assertion checker for the burst-read length block
`timescale 1ns/100ps
`default_nettype none
module fbr_checker (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire fbr_pkg::fbr_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  burst_start,
  input wire logic                  burst_busy,
  input wire logic [7:0]            burst_byte,
  input wire logic                  burst_byte_valid,
  input wire logic                  burst_last,
  input wire logic                  burst_byte_ready
);
  import fbr_pkg::*;
  logic       written;
  logic       burst_en;
  logic [7:0] shadow;
  wire cnt_wr  = reg_req.wr && reg_req.addr == ADDR_READ_COUNT;
  wire cnt_rd  = reg_req.rd && reg_req.addr == ADDR_READ_COUNT && !reg_req.wr;
  wire ctrl_wr = reg_req.wr && reg_req.addr == ADDR_FIFO_CTRL;
  // Shadow of the count and the burst enable, for readback and zero-count starts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      written  <= 1'b0;
      burst_en <= FIFO_CTRL_RESET[FIFO_BURST_BIT];
      shadow   <= READ_COUNT_RESET;
    end else begin
      if (cnt_wr) begin
        written <= 1'b1;
        shadow  <= reg_req.wdata;
      end
      if (ctrl_wr) begin
        burst_en <= reg_req.wdata[FIFO_BURST_BIT];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence cnt_rd_s;
    written && cnt_rd;
  endsequence
  sequence start_s;
    burst_start && !burst_busy && !(burst_en && shadow == 8'h00);
  endsequence
  reset_value_a: assert property (
    cnt_rd && !written |=> reg_rdata == READ_COUNT_RESET) else $error("count reset value wrong");
  write_read_a: assert property (
    cnt_rd_s |=> reg_rdata == $past(shadow)) else $error("count readback wrong");
  byte_hold_a: assert property (
    burst_byte_valid && !burst_byte_ready |=> burst_byte_valid && $stable({burst_byte, burst_last}))
    else $error("burst byte dropped");
  last_valid_a: assert property (
    burst_last |-> burst_byte_valid) else $error("last without valid");
  start_busy_a: assert property (
    start_s |=> burst_busy) else $error("burst start ignored");
endmodule
bind fbr_top fbr_checker i_fbr_checker (.clk(clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .burst_start(burst_start), .burst_busy(burst_busy),
  .burst_byte(burst_byte), .burst_byte_valid(burst_byte_valid), .burst_last(burst_last),
  .burst_byte_ready(burst_byte_ready));
`default_nettype wire

// file: sim/fbr_host.sv
// Host-side byte consumer that stalls at random
`timescale 1ns/100ps
`default_nettype none
module fbr_host (
  input  wire logic clk,
  output logic      burst_byte_ready
);
  integer seed = 32'h3926;
  initial burst_byte_ready = 1'b0;
  always @(negedge clk) burst_byte_ready <= ($random(seed) & 3) != 0;
endmodule
`default_nettype wire

// file: sim/test_fbr_top.sv
// Self-checking bench for the burst-read length block
`timescale 1ns/100ps
`default_nettype none
module test_fbr_top;
  import fbr_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, sample_valid = 1'b0, burst_start = 1'b0;
  logic sample_ready, burst_busy, burst_byte_valid, burst_last, burst_byte_ready;
  logic [7:0] reg_rdata, burst_byte, status_a = 8'h0, status_b = 8'h0;
  logic [1:0] status_bytes = 2'h0;
  logic [SAMPLE_W-1:0] sample_data = '0;
  fbr_reg_req_t reg_req = '0;
  integer seed = 32'h3926, failures = 0, checks = 0;
  logic [SAMPLE_W-1:0] samples[$];
  logic [8:0] expq[$];
  always #12.5 clk = ~clk;
  fbr_top i_fbr_top (.clk, .resetn, .reg_req, .reg_rdata, .sample_valid, .sample_ready,
    .sample_data, .status_a, .status_b, .status_bytes, .burst_start, .burst_busy,
    .burst_byte, .burst_byte_valid, .burst_last, .burst_byte_ready);
  fbr_host i_fbr_host (.clk, .burst_byte_ready);
  task automatic check(input string what, input logic [8:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reg_op(input logic wr, input logic [7:0] addr, wd, exp);
    @(negedge clk) reg_req = '{wr, !wr, addr, wd};
    @(negedge clk) reg_req = '0;
    if (!wr) check("reg_rdata", {1'b0, reg_rdata}, {1'b0, exp});
  endtask
  task automatic push_sample;
    @(negedge clk) sample_data = SAMPLE_W'({$random(seed), $random(seed)});
    sample_valid = 1'b1;
    do @(posedge clk); while (sample_ready !== 1'b1);
    samples.push_back(sample_data);
    @(negedge clk) sample_valid = 1'b0;
  endtask
  task automatic burst(input int n, input logic [1:0] st);
    int k;
    logic [SAMPLE_W-1:0] d;
    status_bytes = st;
    status_a = $random(seed);
    status_b = $random(seed);
    for (int s = 0; s < n; s++) begin
      d = samples.pop_front();
      for (int b = 0; b < 6 + st; b++)
        expq.push_back({s == n - 1 && b == 5 + st,
          b < 6 ? d[8*b+:8] : (b == 6 ? status_a : status_b)});
    end
    @(negedge clk) burst_start = 1'b1;
    @(negedge clk) burst_start = 1'b0;
    k = 0;
    while ((expq.size() > 0 || burst_busy !== 1'b0) && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k == 2000) failures++;
  endtask
  always @(posedge clk) if (burst_byte_valid && burst_byte_ready) begin
    if (expq.size() == 0) check("extra byte", {burst_last, burst_byte}, 9'h1ff);
    else check("burst byte", {burst_last, burst_byte}, expq.pop_front());
  end
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    reg_op(0, ADDR_READ_COUNT, 0, READ_COUNT_RESET);
    reg_op(1, ADDR_READ_COUNT, 8'ha5, 0);
    reg_op(0, ADDR_READ_COUNT, 0, 8'ha5);
    reg_op(0, 8'h7f, 0, 8'h00);
    repeat (FIFO_DEPTH) push_sample();
    @(negedge clk) sample_valid = 1'b1;
    repeat (3) @(negedge clk);
    check("sample_ready", {8'h0, sample_ready}, 9'h0);
    sample_valid = 1'b0;
    reg_op(1, ADDR_READ_COUNT, 8'h02, 0);
    reg_op(1, ADDR_FIFO_CTRL, 8'h80, 0);
    for (int st = 0; st < 3; st++) burst(2, st[1:0]);
    reg_op(1, ADDR_READ_COUNT, 8'h05, 0);
    reg_op(1, ADDR_FIFO_CTRL, 8'h00, 0);
    burst(1, 2'h1);
    reg_op(1, ADDR_READ_COUNT, 8'h09, 0);
    reg_op(1, ADDR_FIFO_CTRL, 8'h80, 0);
    burst(9, 2'h2);
    complete_run();
  end
  initial begin
    #(25 * 20000);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
